// *** gpio_pkg.sv ***
package gpio_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int MODE_W = 2;
	localparam int REG_COUNT = 6;
	// Register addresses
	localparam logic [7:0] ADDR_P0_MODE_LO = 8'hac;
	localparam logic [7:0] ADDR_P0_MODE_HI = 8'had;
	localparam logic [7:0] ADDR_P1_MODE_LO = 8'hae;
	localparam logic [7:0] ADDR_P1_MODE_HI = 8'haf;
	localparam logic [7:0] ADDR_P3_LATCH = 8'hb0;
	localparam logic [7:0] ADDR_P2_MODE_LO = 8'hb1;
	// Storage index of each register, address minus the first address
	localparam logic [2:0] IDX_P0_LO = 3'h0;
	localparam logic [2:0] IDX_P0_HI = 3'h1;
	localparam logic [2:0] IDX_P1_LO = 3'h2;
	localparam logic [2:0] IDX_P1_HI = 3'h3;
	localparam logic [2:0] IDX_P3_LATCH = 3'h4;
	localparam logic [2:0] IDX_P2_LO = 3'h5;
	// Reset values
	localparam logic [7:0] MODE_REG_RST = 8'h00;
	localparam logic [7:0] P3_LATCH_RST = 8'hff;
	localparam logic [2:0] DRIVE_RST = 3'h1;
	// Pin mode field codes, upper bit then lower bit
	localparam logic [1:0] MODE_QUASI = 2'h0;
	localparam logic [1:0] MODE_PUSH = 2'h1;
	localparam logic [1:0] MODE_OPEN = 2'h2;
	localparam logic [1:0] MODE_INPUT = 2'h3;
	// Port 3 alternate function bit positions
	localparam int P3_RD_BIT = 7;
	localparam int P3_WR_BIT = 6;
	localparam int P3_CNT1_BIT = 5;
	localparam int P3_CNT0_BIT = 4;
	localparam int P3_IRQ1_BIT = 3;
	localparam int P3_IRQ0_BIT = 2;
	localparam int P3_TX_BIT = 1;
	localparam int P3_RX_BIT = 0;
	// Layout of the synchronised pin vector
	localparam int SYNC_W = 29;
	localparam int SYNC_P0 = 0;
	localparam int SYNC_P1 = 8;
	localparam int SYNC_P2 = 16;
	localparam int SYNC_P3 = 20;
	localparam int SYNC_EA = 28;
endpackage : gpio_pkg

// *** pin_drive_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface pin_drive_if #(parameter int WIDTH = 8) ();
	logic [2*WIDTH-1:0] mode;
	logic [WIDTH-1:0] data;
	logic [WIDTH-1:0] force_en;
	logic [WIDTH-1:0] force_out;
	logic [WIDTH-1:0] force_oe;
	logic [WIDTH-1:0] pin_out;
	logic [WIDTH-1:0] pin_oe;
	logic [WIDTH-1:0] pull_up;
	modport ctrl (output mode, data, force_en, force_out, force_oe,
		input pin_out, pin_oe, pull_up);
	modport drv (input mode, data, force_en, force_out, force_oe,
		output pin_out, pin_oe, pull_up);
endinterface : pin_drive_if
`default_nettype wire

// *** pin_driver.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_driver #(parameter int WIDTH = 8) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// Pin control
	pin_drive_if.drv bus
);
	import gpio_pkg::*;

	// Result is {oe, out, pull}
	function automatic logic [2:0] drive_of(input logic [1:0] mode, input logic d);
		logic [2:0] r;
		r = 3'h0;
		unique case (mode)
			MODE_QUASI: r = {~d, 1'b0, 1'b1};
			MODE_PUSH: r = {1'b1, d, 1'b0};
			MODE_OPEN: r = {~d, 1'b0, 1'b0};
			MODE_INPUT: r = 3'h0;
		endcase
		return r;
	endfunction : drive_of

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_pin
			logic [2:0] drv_d;
			logic [2:0] drv_q;
			always_comb begin
				if (bus.force_en[g]) begin
					drv_d = {bus.force_oe[g], bus.force_out[g], 1'b0};
				end else begin
					drv_d = drive_of(bus.mode[2*g +: 2], bus.data[g]);
				end
			end
			// Registered so the pads never see decode glitches
			always_ff @(posedge i_core_clk) begin
				if (!i_rst_n) begin
					drv_q <= DRIVE_RST;
				end else begin
					drv_q <= drv_d;
				end
			end
			assign bus.pin_oe[g] = drv_q[2];
			assign bus.pin_out[g] = drv_q[1];
			assign bus.pull_up[g] = drv_q[0];

			property p_quasi_drive;
				@(posedge i_core_clk) disable iff (!i_rst_n)
				(bus.mode[2*g +: 2] == MODE_QUASI && !bus.force_en[g])
				|=> (bus.pin_oe[g] == !$past(bus.data[g])) && bus.pull_up[g];
			endproperty
			a_quasi_drive: assert property (p_quasi_drive)
				else $error("Quasi pin drive wrong");
			property p_input_float;
				@(posedge i_core_clk) disable iff (!i_rst_n)
				(bus.mode[2*g +: 2] == MODE_INPUT && !bus.force_en[g])
				|=> !bus.pin_oe[g] && !bus.pull_up[g];
			endproperty
			a_input_float: assert property (p_input_float)
				else $error("Input pin is driven");
			property p_push_drive;
				@(posedge i_core_clk) disable iff (!i_rst_n)
				(bus.mode[2*g +: 2] == MODE_PUSH && !bus.force_en[g])
				|=> bus.pin_oe[g] && (bus.pin_out[g] == $past(bus.data[g]));
			endproperty
			a_push_drive: assert property (p_push_drive)
				else $error("Push-pull pin drive wrong");
		end
	endgenerate
endmodule : pin_driver
`default_nettype wire

// *** port_pin_mode_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Port 0 low register: pins 3..0, two bits each
// - Port 0 high register: pins 7..4, two bits each
// - Port 1 low register: pins 3..0
// - Port 1 high register: pins 7..4
// - Port 2 low register: port 2 pins 3..0
// - Mode codes: quasi, push-pull, open-drain, input
// - All mode registers reset to zero
// - External access and memory control take port 0
// - Port 3 latch, eight bits, resets to ff
// - Pin 7 read strobe when external memory
// - Pin 6 write strobe when external memory
// - Strobe pins ignore mode bits under external memory
// - Pin 5 falling edge counts timer 1
// - Pin 4 falling edge counts timer 0
// - Pin 3 edge or low raises interrupt 1
// - Pin 2 edge or low raises interrupt 0
// - Pin 1 serial transmit or mode-0 clock
// - Pin 0 serial receive or mode-0 data
module port_pin_mode_ctrl (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// Special function register access
	input wire logic [gpio_pkg::ADDR_W-1:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic i_sfr_rd,
	input wire logic [gpio_pkg::DATA_W-1:0] i_sfr_wdata,
	output logic [gpio_pkg::DATA_W-1:0] o_sfr_rdata,
	output logic o_sfr_ack,
	// External memory selection
	input wire logic i_external_access_pin_n,
	input wire logic i_mem_access_p0_ext,
	input wire logic i_mem_access_p2_ext,
	input wire logic [7:0] i_xmem_p0_out,
	input wire logic i_xmem_p0_oe,
	input wire logic [3:0] i_xmem_p2_out,
	input wire logic i_xmem_rd_n,
	input wire logic i_xmem_wr_n,
	// Port data latches and port 3 modes held elsewhere
	input wire logic [7:0] i_port0_data,
	input wire logic [7:0] i_port1_data,
	input wire logic [3:0] i_port2_data,
	input wire logic [15:0] i_port3_mode,
	// Serial port 0
	input wire logic i_serial0_mode0,
	input wire logic i_serial0_tx,
	input wire logic i_serial0_rx_out,
	output logic o_serial0_rx_data,
	// Timer and interrupt control
	input wire logic i_ext_irq0_en,
	input wire logic i_ext_irq0_edge,
	input wire logic i_ext_irq1_en,
	input wire logic i_ext_irq1_edge,
	output logic o_counter0_ext_tick,
	output logic o_counter1_ext_tick,
	output logic o_ext_irq0_req,
	output logic o_ext_irq1_req,
	// Port 0 pins
	input wire logic [7:0] i_port0_pin,
	output logic [7:0] o_port0_pin,
	output logic [7:0] o_port0_oe,
	output logic [7:0] o_port0_pull,
	output logic [7:0] o_port0_level,
	// Port 1 pins
	input wire logic [7:0] i_port1_pin,
	output logic [7:0] o_port1_pin,
	output logic [7:0] o_port1_oe,
	output logic [7:0] o_port1_pull,
	output logic [7:0] o_port1_level,
	// Port 2 pins 3..0
	input wire logic [3:0] i_port2_pin,
	output logic [3:0] o_port2_pin,
	output logic [3:0] o_port2_oe,
	output logic [3:0] o_port2_pull,
	output logic [3:0] o_port2_level,
	// Port 3 pins
	input wire logic [7:0] i_port3_pin,
	output logic [7:0] o_port3_pin,
	output logic [7:0] o_port3_oe,
	output logic [7:0] o_port3_pull
);
	import gpio_pkg::*;

	logic [DATA_W-1:0] regs_q [REG_COUNT];
	logic [SYNC_W-1:0] meta_q;
	logic [SYNC_W-1:0] sync_q;
	logic [SYNC_W-1:0] prev_q;
	logic [7:0] p3_lvl;
	logic [7:0] p3_fall;
	logic [7:0] p3_alt;
	logic ea_active;
	logic p0_ext;
	logic p2_ext;
	logic strobe_en;
	logic [3:0] wr_dec;
	logic [3:0] rd_dec;

	// Returns {hit, index}
	function automatic logic [3:0] decode(input logic [7:0] addr);
		logic [7:0] off;
		off = addr - ADDR_P0_MODE_LO;
		return {(addr >= ADDR_P0_MODE_LO) && (addr <= ADDR_P2_MODE_LO), off[2:0]};
	endfunction : decode

	assign wr_dec = decode(i_sfr_addr);
	assign rd_dec = decode(i_sfr_addr);

	// Register writes
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			for (int k = 0; k < REG_COUNT; k++) begin
				if (3'(k) == IDX_P3_LATCH) begin
					regs_q[k] <= P3_LATCH_RST;
				end else begin
					regs_q[k] <= MODE_REG_RST;
				end
			end
		end else if (i_sfr_wr && wr_dec[3]) begin
			regs_q[wr_dec[2:0]] <= i_sfr_wdata;
		end
	end

	// Register reads, one cycle after the strobe
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_sfr_rdata <= '0;
			o_sfr_ack <= 1'b0;
		end else begin
			o_sfr_ack <= i_sfr_rd && rd_dec[3];
			if (i_sfr_rd) begin
				if (!rd_dec[3]) begin
					o_sfr_rdata <= '0;
				end else if (rd_dec[2:0] == IDX_P3_LATCH) begin
					o_sfr_rdata <= p3_lvl;
				end else begin
					o_sfr_rdata <= regs_q[rd_dec[2:0]];
				end
			end
		end
	end

	// Two-stage synchroniser for every pin; prev_q feeds edge detection only
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			meta_q <= '1;
			sync_q <= '1;
			prev_q <= '1;
		end else begin
			meta_q <= {i_external_access_pin_n, i_port3_pin, i_port2_pin,
				i_port1_pin, i_port0_pin};
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign p3_lvl = sync_q[SYNC_P3 +: 8];
	assign p3_fall = prev_q[SYNC_P3 +: 8] & ~sync_q[SYNC_P3 +: 8];
	assign ea_active = !sync_q[SYNC_EA];
	assign p0_ext = ea_active || i_mem_access_p0_ext;
	assign p2_ext = ea_active || i_mem_access_p2_ext;
	assign strobe_en = p0_ext || p2_ext;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_port0_level <= '1;
			o_port1_level <= '1;
			o_port2_level <= '1;
			o_serial0_rx_data <= 1'b1;
		end else begin
			o_port0_level <= sync_q[SYNC_P0 +: 8];
			o_port1_level <= sync_q[SYNC_P1 +: 8];
			o_port2_level <= sync_q[SYNC_P2 +: 4];
			o_serial0_rx_data <= p3_lvl[P3_RX_BIT];
		end
	end

	// Timer count inputs
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_counter0_ext_tick <= 1'b0;
			o_counter1_ext_tick <= 1'b0;
		end else begin
			o_counter1_ext_tick <= p3_fall[P3_CNT1_BIT];
			o_counter0_ext_tick <= p3_fall[P3_CNT0_BIT];
		end
	end

	// Edge or level request; the interrupt block latches and clears it
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_ext_irq0_req <= 1'b0;
			o_ext_irq1_req <= 1'b0;
		end else begin
			o_ext_irq1_req <= i_ext_irq1_en && (i_ext_irq1_edge ?
				p3_fall[P3_IRQ1_BIT] : !p3_lvl[P3_IRQ1_BIT]);
			o_ext_irq0_req <= i_ext_irq0_en && (i_ext_irq0_edge ?
				p3_fall[P3_IRQ0_BIT] : !p3_lvl[P3_IRQ0_BIT]);
		end
	end

	// Alternate outputs are ANDed with the latch, so a zero latch blocks them
	always_comb begin
		p3_alt = '1;
		p3_alt[P3_TX_BIT] = i_serial0_tx;
		p3_alt[P3_RX_BIT] = i_serial0_mode0 ? i_serial0_rx_out : 1'b1;
	end

	pin_drive_if #(.WIDTH(8)) p0_if ();
	pin_drive_if #(.WIDTH(8)) p1_if ();
	pin_drive_if #(.WIDTH(4)) p2_if ();
	pin_drive_if #(.WIDTH(8)) p3_if ();

	assign p0_if.mode = {regs_q[IDX_P0_HI], regs_q[IDX_P0_LO]};
	assign p0_if.data = i_port0_data;
	assign p0_if.force_en = {8{p0_ext}};
	assign p0_if.force_out = i_xmem_p0_out;
	assign p0_if.force_oe = {8{i_xmem_p0_oe}};

	assign p1_if.mode = {regs_q[IDX_P1_HI], regs_q[IDX_P1_LO]};
	assign p1_if.data = i_port1_data;
	assign p1_if.force_en = '0;
	assign p1_if.force_out = '0;
	assign p1_if.force_oe = '0;

	assign p2_if.mode = regs_q[IDX_P2_LO];
	assign p2_if.data = i_port2_data;
	assign p2_if.force_en = {4{p2_ext}};
	assign p2_if.force_out = i_xmem_p2_out;
	assign p2_if.force_oe = '1;

	// Strobes bypass the mode bits and the latch
	assign p3_if.mode = i_port3_mode;
	assign p3_if.data = regs_q[IDX_P3_LATCH] & p3_alt;
	assign p3_if.force_en = {strobe_en, strobe_en, 6'h00};
	assign p3_if.force_out = {i_xmem_rd_n, i_xmem_wr_n, 6'h00};
	assign p3_if.force_oe = {2'h3, 6'h00};

	pin_driver #(.WIDTH(8)) u_p0 (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .bus(p0_if));
	pin_driver #(.WIDTH(8)) u_p1 (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .bus(p1_if));
	pin_driver #(.WIDTH(4)) u_p2 (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .bus(p2_if));
	pin_driver #(.WIDTH(8)) u_p3 (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .bus(p3_if));

	assign o_port0_pin = p0_if.pin_out;
	assign o_port0_oe = p0_if.pin_oe;
	assign o_port0_pull = p0_if.pull_up;
	assign o_port1_pin = p1_if.pin_out;
	assign o_port1_oe = p1_if.pin_oe;
	assign o_port1_pull = p1_if.pull_up;
	assign o_port2_pin = p2_if.pin_out;
	assign o_port2_oe = p2_if.pin_oe;
	assign o_port2_pull = p2_if.pull_up;
	assign o_port3_pin = p3_if.pin_out;
	assign o_port3_oe = p3_if.pin_oe;
	assign o_port3_pull = p3_if.pull_up;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	property p_mode_reset;
		$rose(i_rst_n) |-> (regs_q[IDX_P0_LO] == 8'h00) && (regs_q[IDX_P1_HI] == 8'h00)
			&& (regs_q[IDX_P2_LO] == 8'h00);
	endproperty
	a_mode_reset: assert property (p_mode_reset)
		else $error("Mode register not zero after reset");

	property p_latch_reset;
		$rose(i_rst_n) |-> regs_q[IDX_P3_LATCH] == P3_LATCH_RST;
	endproperty
	a_latch_reset: assert property (p_latch_reset)
		else $error("Port 3 latch not ff after reset");

	property p_p0_low_input;
		(i_sfr_wr && i_sfr_addr == ADDR_P0_MODE_LO && i_sfr_wdata[7:6] == 2'h3) ##1 !p0_ext
			|=> !o_port0_oe[3];
	endproperty
	a_p0_low_input: assert property (p_p0_low_input)
		else $error("Port 0 pin 3 driven in input mode");

	property p_p0_high_push;
		(i_sfr_wr && i_sfr_addr == ADDR_P0_MODE_HI && i_sfr_wdata[1:0] == 2'h1) ##1 !p0_ext
			|=> o_port0_oe[4] && (o_port0_pin[4] == $past(i_port0_data[4]));
	endproperty
	a_p0_high_push: assert property (p_p0_high_push)
		else $error("Port 0 pin 4 not push-pull");

	property p_p1_low_open;
		(i_sfr_wr && i_sfr_addr == ADDR_P1_MODE_LO && i_sfr_wdata[7:6] == 2'h2) ##1 1'b1
			|=> (o_port1_oe[3] == !$past(i_port1_data[3])) && !o_port1_pin[3]
			&& !o_port1_pull[3];
	endproperty
	a_p1_low_open: assert property (p_p1_low_open)
		else $error("Port 1 pin 3 not open-drain");

	property p_p2_low_input;
		(i_sfr_wr && i_sfr_addr == ADDR_P2_MODE_LO && i_sfr_wdata[1:0] == 2'h3) ##1 !p2_ext
			|=> !o_port2_oe[0];
	endproperty
	a_p2_low_input: assert property (p_p2_low_input)
		else $error("Port 2 pin 0 driven in input mode");

	property p_p0_external;
		p0_ext |=> (o_port0_pin == $past(i_xmem_p0_out))
			&& (o_port0_oe == {8{$past(i_xmem_p0_oe)}});
	endproperty
	a_p0_external: assert property (p_p0_external)
		else $error("Port 0 not handed to external memory");

	property p_strobes;
		strobe_en |=> o_port3_oe[7] && o_port3_oe[6]
			&& (o_port3_pin[7:6] == {$past(i_xmem_rd_n), $past(i_xmem_wr_n)});
	endproperty
	a_strobes: assert property (p_strobes)
		else $error("Memory strobes not driven");

	property p_count1;
		$fell(sync_q[SYNC_P3 + P3_CNT1_BIT]) |=> o_counter1_ext_tick ##1 !o_counter1_ext_tick;
	endproperty
	a_count1: assert property (p_count1)
		else $error("Timer 1 count pulse wrong");

	property p_irq1_level;
		(i_ext_irq1_en && !i_ext_irq1_edge && !p3_lvl[P3_IRQ1_BIT]) |=> o_ext_irq1_req;
	endproperty
	a_irq1_level: assert property (p_irq1_level)
		else $error("Level interrupt 1 not raised");

	property p_p3_read;
		(i_sfr_rd && i_sfr_addr == ADDR_P3_LATCH) |=> o_sfr_ack && (o_sfr_rdata == $past(p3_lvl));
	endproperty
	a_p3_read: assert property (p_p3_read)
		else $error("Port 3 read is not the pin level");
endmodule : port_pin_mode_ctrl
`default_nettype wire

// *** pin_world.sv ***
`timescale 1ns/1ps
`default_nettype none
// Board side of a pin group; a released pin without pull-up wanders
module pin_world #(parameter int W = 8) (
	// Clock
	input wire logic i_core_clk,
	// Chip side
	input wire logic [W-1:0] i_out,
	input wire logic [W-1:0] i_oe,
	input wire logic [W-1:0] i_pull,
	// Board drivers
	input wire logic [W-1:0] i_ext_en,
	input wire logic [W-1:0] i_ext_val,
	output logic [W-1:0] o_level
);
	logic [W-1:0] wander_q = '0;
	always_ff @(posedge i_core_clk) begin
		wander_q <= ~wander_q;
	end
	// Chip drive wins over the board so contention never shows as X
	always_comb begin
		for (int i = 0; i < W; i++) begin
			o_level[i] = i_oe[i] ? i_out[i] : i_ext_en[i] ? i_ext_val[i] : i_pull[i] | wander_q[i];
		end
	end
endmodule : pin_world
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
	import gpio_pkg::*;
	logic i_core_clk = 0;
	logic i_rst_n = 0;
	logic [7:0] addr = '0, wdata = '0, rdata, xp0 = '0, d0 = '0, d1 = '0, sh2 = '0;
	logic wr = 0, rd = 0, ack, ea_n = 1, m0 = 0, m2 = 0, xoe = 0, xrd = 1, xwr = 1;
	logic smode0 = 0, stx = 1, srx = 1, ie0 = 0, ie1 = 0, ed0 = 1, ed1 = 1;
	logic rxd, t0, t1, q0, q1;
	logic [3:0] xp2 = '0, d2 = '0, p2o, p2e, p2u, p2l, w2;
	logic [15:0] p3m = '0, sh0 = '0, sh1 = '0;
	logic [7:0] p0o, p0e, p0u, p0l, p1o, p1e, p1u, p1l, p3o, p3e, p3u, w0, w1, w3;
	logic [7:0] ext_en = '0, ext_val = '0, bd_en = '0, bd_val = '0;
	logic [7:0] regs [6] = '{ADDR_P0_MODE_LO, ADDR_P0_MODE_HI, ADDR_P1_MODE_LO,
		ADDR_P1_MODE_HI, ADDR_P3_LATCH, ADDR_P2_MODE_LO};
	int fails = 0, checked = 0, n_t0 = 0, n_t1 = 0, n_q0 = 0;

	always #10 i_core_clk = ~i_core_clk;

	port_pin_mode_ctrl DUT (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_sfr_addr(addr),
		.i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
		.o_sfr_ack(ack), .i_external_access_pin_n(ea_n), .i_mem_access_p0_ext(m0),
		.i_mem_access_p2_ext(m2), .i_xmem_p0_out(xp0), .i_xmem_p0_oe(xoe),
		.i_xmem_p2_out(xp2), .i_xmem_rd_n(xrd), .i_xmem_wr_n(xwr), .i_port0_data(d0),
		.i_port1_data(d1), .i_port2_data(d2), .i_port3_mode(p3m), .i_serial0_mode0(smode0),
		.i_serial0_tx(stx), .i_serial0_rx_out(srx), .o_serial0_rx_data(rxd),
		.i_ext_irq0_en(ie0), .i_ext_irq0_edge(ed0), .i_ext_irq1_en(ie1),
		.i_ext_irq1_edge(ed1), .o_counter0_ext_tick(t0), .o_counter1_ext_tick(t1),
		.o_ext_irq0_req(q0), .o_ext_irq1_req(q1), .i_port0_pin(w0), .o_port0_pin(p0o),
		.o_port0_oe(p0e), .o_port0_pull(p0u), .o_port0_level(p0l), .i_port1_pin(w1),
		.o_port1_pin(p1o), .o_port1_oe(p1e), .o_port1_pull(p1u), .o_port1_level(p1l),
		.i_port2_pin(w2), .o_port2_pin(p2o), .o_port2_oe(p2e), .o_port2_pull(p2u),
		.o_port2_level(p2l), .i_port3_pin(w3), .o_port3_pin(p3o), .o_port3_oe(p3e),
		.o_port3_pull(p3u));

	pin_world #(.W(8)) pw0 (.i_core_clk(i_core_clk), .i_out(p0o), .i_oe(p0e), .i_pull(p0u),
		.i_ext_en(bd_en), .i_ext_val(bd_val), .o_level(w0));
	pin_world #(.W(8)) pw1 (.i_core_clk(i_core_clk), .i_out(p1o), .i_oe(p1e), .i_pull(p1u),
		.i_ext_en(bd_en), .i_ext_val(bd_val), .o_level(w1));
	pin_world #(.W(4)) pw2 (.i_core_clk(i_core_clk), .i_out(p2o), .i_oe(p2e), .i_pull(p2u),
		.i_ext_en(bd_en[3:0]), .i_ext_val(bd_val[3:0]), .o_level(w2));
	pin_world #(.W(8)) pw3 (.i_core_clk(i_core_clk), .i_out(p3o), .i_oe(p3e), .i_pull(p3u),
		.i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(w3));

	// Pulse counts; each high cycle counts, so a stretched pulse shows up
	always @(negedge i_core_clk) begin
		if (t0 === 1'b1) n_t0++;
		if (t1 === 1'b1) n_t1++;
		if (q0 === 1'b1) n_q0++;
	end

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge i_core_clk);
	endtask : cyc

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_core_clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge i_core_clk);
		wr = 1'b0;
	endtask : wr_reg

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic k);
		@(negedge i_core_clk);
		addr = a;
		rd = 1'b1;
		@(negedge i_core_clk);
		rd = 1'b0;
		chk("rdata", e, rdata);
		chk("ack", {7'h0, k}, {7'h0, ack});
	endtask : rd_chk

	// k: 0 oe, 1 driven value, 2 pull
	function automatic logic [7:0] pin_exp(input logic [15:0] m, input logic [7:0] d, input int k);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			case (k)
				0: r[i] = m[2*i] ? !m[2*i+1] : !d[i];
				1: r[i] = (m[2*i+:2] == MODE_PUSH) & d[i];
				default: r[i] = (m[2*i+:2] == MODE_QUASI);
			endcase
		end
		return r;
	endfunction : pin_exp

	task automatic chk_port(input string nm, input logic [15:0] m, input logic [7:0] d,
		input logic [7:0] oe, input logic [7:0] o, input logic [7:0] pu);
		logic [7:0] eo;
		eo = pin_exp(m, d, 0);
		chk({nm, " oe"}, eo, oe);
		chk({nm, " out"}, pin_exp(m, d, 1), o & eo);
		chk({nm, " pull"}, pin_exp(m, d, 2), pu);
	endtask : chk_port

	task automatic pulse(input int b);
		ext_en[b] = 1'b1;
		ext_val[b] = 1'b0;
		cyc(5);
		ext_en[b] = 1'b0;
		cyc(5);
	endtask : pulse

	initial begin
		repeat (5000) @(posedge i_core_clk);
		fails++;
		tally_and_finish();
	end

	initial begin
		int k;
		logic [7:0] v;
		void'($urandom(49));
		cyc(3);
		i_rst_n = 1'b1;
		for (int i = 0; i < 6; i++)
			rd_chk(regs[i], (i == 4) ? P3_LATCH_RST : MODE_REG_RST, 1'b1);
		rd_chk(8'hb2, 8'h00, 1'b0);
		chk_port("p0", sh0, d0, p0e, p0o, p0u);
		// First five writes give each mode register every code once
		for (int it = 0; it < 25; it++) begin
			k = (it < 5) ? it : $urandom_range(0, 4);
			v = (it < 5) ? 8'he4 : 8'($urandom);
			d0 = 8'($urandom);
			d1 = 8'($urandom);
			d2 = 4'($urandom);
			case (k)
				0: sh0[7:0] = v;
				1: sh0[15:8] = v;
				2: sh1[7:0] = v;
				3: sh1[15:8] = v;
				default: sh2 = v;
			endcase
			wr_reg(regs[(k == 4) ? 5 : k], v);
			rd_chk(regs[(k == 4) ? 5 : k], v, 1'b1);
			cyc(1);
			chk_port("p0", sh0, d0, p0e, p0o, p0u);
			chk_port("p1", sh1, d1, p1e, p1o, p1u);
			chk_port("p2", {8'hff, sh2}, {4'h0, d2}, {4'h0, p2e}, {4'h0, p2o}, {4'h0, p2u});
		end
		// Port 0, 1 and 2 pins released to input, then the board drives them
		for (int i = 0; i < 6; i++)
			if (i != 4) wr_reg(regs[i], 8'hff);
		bd_val = 8'($urandom);
		bd_en = 8'hff;
		cyc(5);
		chk("p0 level", bd_val, p0l);
		chk("p1 level", bd_val, p1l);
		chk("p2 level", {4'h0, bd_val[3:0]}, {4'h0, p2l});
		wr_reg(ADDR_P3_LATCH, 8'h5a);
		cyc(2);
		chk("p3 oe", 8'ha5, p3e);
		chk("p3 pull", 8'hff, p3u);
		cyc(2);
		rd_chk(ADDR_P3_LATCH, 8'h5a, 1'b1);
		// Strobe latch bits cleared and strobe pins set to input on purpose
		p3m = 16'hf000;
		wr_reg(ADDR_P3_LATCH, 8'h3f);
		for (int s = 0; s < 3; s++) begin
			m0 = (s == 0);
			m2 = (s == 1);
			ea_n = (s != 2);
			xoe = 1'($urandom);
			xp0 = 8'($urandom);
			xp2 = 4'($urandom);
			xrd = 1'(s);
			xwr = !xrd;
			cyc(4);
			chk("strobe oe", 8'hc0, p3e & 8'hc0);
			chk("strobe lvl", {xrd, xwr, 6'h0}, w3 & 8'hc0);
			if (s != 1) begin
				chk("xmem p0 oe", {8{xoe}}, p0e);
				chk("xmem p0 out", xp0 & {8{xoe}}, p0o & {8{xoe}});
			end
			if (s != 0) chk("xmem p2", {4'hf, xp2}, {p2e, p2o});
		end
		m0 = 1'b0;
		m2 = 1'b0;
		ea_n = 1'b1;
		p3m = 16'h0000;
		wr_reg(ADDR_P3_LATCH, 8'hff);
		cyc(4);
		n_t0 = 0;
		n_t1 = 0;
		n_q0 = 0;
		ie0 = 1'b1;
		ie1 = 1'b1;
		ed1 = 1'b0;
		for (int i = 0; i < 3; i++) begin
			pulse(5);
			pulse(4);
			pulse(2);
		end
		ie0 = 1'b0;
		pulse(2);
		chk("t1 ticks", 8'h03, 8'(n_t1));
		chk("t0 ticks", 8'h03, 8'(n_t0));
		chk("irq0 pulses", 8'h03, 8'(n_q0));
		ext_en[3] = 1'b1;
		cyc(6);
		chk("irq1 low", 8'h01, {7'h0, q1});
		ext_en[3] = 1'b0;
		cyc(4);
		chk("irq1 high", 8'h00, {7'h0, q1});
		ie0 = 1'b1;
		ed0 = 1'b0;
		ext_en[2] = 1'b1;
		cyc(6);
		chk("irq0 low", 8'h01, {7'h0, q0});
		ext_en[2] = 1'b0;
		cyc(4);
		chk("irq0 high", 8'h00, {7'h0, q0});
		for (int b = 0; b < 2; b++) begin
			stx = 1'(b);
			smode0 = 1'b1;
			srx = 1'(b);
			cyc(3);
			chk("tx pin", {7'h0, stx}, {7'h0, w3[1]});
			chk("mode0 data pin", {7'h0, srx}, {7'h0, w3[0]});
			smode0 = 1'b0;
			ext_en[0] = 1'b1;
			ext_val[0] = !srx;
			cyc(4);
			chk("rx data", {7'h0, !srx}, {7'h0, rxd});
			ext_en[0] = 1'b0;
		end
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
